// ==== core/slpcg_ctrl.sv ====
// Sleep mode, clock domain gating, wake filtering and peripheral clock gates
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "slpcg_map.svh"
module slpcg_ctrl #(
    parameter int CW = `SLPCG_CNT_W
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rstn_i,
    // Register port
    input  wire logic [`SLPCG_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic [7:0]                    rdata_o,
    // Core side
    input  wire logic                     sleep_instr_i,
    input  wire logic                     crystal_sel_i,
    input  wire logic [CW-1:0]            fuse_timeout_i,
    // Wake sources
    input  wire logic [3:0]               ext_level_irq_i,
    input  wire logic                     stage_ctrl_irq_i,
    input  wire logic                     store_ready_irq_i,
    input  wire logic                     converter_irq_i,
    input  wire logic                     watchdog_wake_i,
    input  wire logic                     other_io_irq_i,
    input  wire logic                     conv_enable_i,
    // Clock domain enables
    output logic                          clk_core_en_o,
    output logic                          clk_flash_en_o,
    output logic                          clk_io_en_o,
    output logic                          clk_conv_en_o,
    output logic                          clk_pll_en_o,
    output logic                          osc_en_o,
    // Peripheral clock enables and register access enables
    output logic [7:0]                    periph_clk_en_o,
    output logic [7:0]                    periph_acc_en_o,
    output logic                          comp_mux_en_o,
    output logic                          conv_extended_o,
    output logic                          core_halt_o,
    output logic                          irq_service_o
);
    import slpcg_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]   mode_ctrl_reg;
    logic [7:0]   clk_gate_reg;
    logic [2:0]   mode_reg;
    logic         conv_ext_reg;
    logic         conv_en_d_reg;
    slpcg_state_t state_reg;
    logic         cnt_load;
    logic [CW-1:0] cnt_val;
    logic         cnt_done;
    logic [2:0]   sm_sel;
    logic         se_bit;
    logic         wake_hit;
    logic         mode_valid;
    logic         pdown_like;

    assign sm_sel = mode_ctrl_reg[`SLPCG_SM_MSB:`SLPCG_SM_LSB];
    assign se_bit = mode_ctrl_reg[`SLPCG_SE_BIT];

    // Modes the block can honour; standby needs crystal option
    always_comb begin
        mode_valid = 1'b0;
        case (sm_sel)
            `SLPCG_SM_IDLE:  mode_valid = 1'b1;
            `SLPCG_SM_NOISE: mode_valid = 1'b1;
            `SLPCG_SM_PDOWN: mode_valid = 1'b1;
            `SLPCG_SM_STBY:  mode_valid = crystal_sel_i;
            default:         mode_valid = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Mode control: upper nibble reserved
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mode_ctrl_reg <= `SLPCG_MODE_CTRL_RST;
        end else if (wr_i && addr_i == `SLPCG_OFF_MODE_CTRL) begin
            mode_ctrl_reg <= {4'h0, wdata_i[3:0]};
        end
    end

    // Peripheral gate register, all bits read/write
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            clk_gate_reg <= `SLPCG_CLK_GATE_RST;
        end else if (wr_i && addr_i == `SLPCG_OFF_CLK_GATE) begin
            clk_gate_reg <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == `SLPCG_OFF_MODE_CTRL) begin
                rdata_o <= mode_ctrl_reg;
            end else if (addr_i == `SLPCG_OFF_CLK_GATE) begin
                rdata_o <= clk_gate_reg;
            end else if (addr_i == `SLPCG_OFF_STATUS) begin
                rdata_o <= {2'b00, conv_ext_reg, mode_reg, state_reg[1:0]};
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Wake source filtering per mode
    // ------------------------------------------------------------
    always_comb begin
        wake_hit = 1'b0;
        case (mode_reg)
            `SLPCG_SM_IDLE: begin
                wake_hit = |ext_level_irq_i | stage_ctrl_irq_i
                         | store_ready_irq_i | converter_irq_i
                         | watchdog_wake_i | other_io_irq_i;
            end
            `SLPCG_SM_NOISE: begin
                wake_hit = |ext_level_irq_i | stage_ctrl_irq_i
                         | store_ready_irq_i | converter_irq_i
                         | watchdog_wake_i;
            end
            `SLPCG_SM_PDOWN: begin
                wake_hit = |ext_level_irq_i | stage_ctrl_irq_i
                         | watchdog_wake_i;
            end
            `SLPCG_SM_STBY: begin
                wake_hit = |ext_level_irq_i | watchdog_wake_i;
            end
            default: wake_hit = 1'b0;
        endcase
    end

    assign pdown_like = (mode_reg == `SLPCG_SM_PDOWN);

    // Restart delay: fuse time-out for power-down, short for standby
    always_comb begin
        cnt_load = 1'b0;
        cnt_val  = '0;
        if (state_reg == SLPCG_SLEEP && wake_hit) begin
            cnt_load = 1'b1;
            if (pdown_like) begin
                cnt_val = fuse_timeout_i;
            end else begin
                cnt_val = '0;
            end
        end else if (state_reg == SLPCG_START && cnt_done) begin
            cnt_load = 1'b1;
            cnt_val  = CW'(`SLPCG_IRQ_HOLD_CYC - 1);
        end
    end

    slpcg_wake_cnt #(
        .CW (CW)
    ) u_wake_cnt (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .load_i    (cnt_load),
        .value_i   (cnt_val),
        .done_o    (cnt_done)
    );

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_reg <= SLPCG_RUN;
            mode_reg  <= `SLPCG_SM_IDLE;
        end else begin
            case (state_reg)
                SLPCG_RUN: begin
                    if (sleep_instr_i && se_bit && mode_valid) begin
                        state_reg <= SLPCG_SLEEP;
                        mode_reg  <= sm_sel;
                    end
                end
                SLPCG_SLEEP: begin
                    if (wake_hit) begin
                        state_reg <= SLPCG_START;
                    end
                end
                SLPCG_START: begin
                    if (cnt_done) begin
                        state_reg <= SLPCG_HOLD;
                    end
                end
                SLPCG_HOLD: begin
                    if (cnt_done) begin
                        state_reg <= SLPCG_RUN;
                    end
                end
                default: state_reg <= SLPCG_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock domain enables
    // ------------------------------------------------------------
    always_comb begin
        clk_core_en_o  = (state_reg == SLPCG_RUN);
        clk_flash_en_o = (state_reg == SLPCG_RUN);
        clk_io_en_o    = 1'b1;
        clk_conv_en_o  = 1'b1;
        clk_pll_en_o   = 1'b1;
        osc_en_o       = 1'b1;
        if (state_reg == SLPCG_SLEEP) begin
            case (mode_reg)
                `SLPCG_SM_NOISE: begin
                    clk_io_en_o = 1'b0;
                end
                `SLPCG_SM_PDOWN: begin
                    clk_io_en_o   = 1'b0;
                    clk_conv_en_o = 1'b0;
                    clk_pll_en_o  = 1'b0;
                    osc_en_o      = 1'b0;
                end
                `SLPCG_SM_STBY: begin
                    clk_io_en_o   = 1'b0;
                    clk_conv_en_o = 1'b0;
                    clk_pll_en_o  = 1'b0;
                    osc_en_o      = 1'b1;
                end
                default: begin
                    clk_io_en_o = 1'b1;
                end
            endcase
        end else if (state_reg == SLPCG_START && pdown_like) begin
            clk_io_en_o   = 1'b0;
            clk_conv_en_o = 1'b0;
            clk_pll_en_o  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Peripheral gates
    // ------------------------------------------------------------
    // Gate bits stop access, and clocks except for the timers; ungating resumes frozen state
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_gate
            logic dom_en;
            if (g >= `SLPCG_G_PSC0 || g == `SLPCG_G_SPI
                || g == `SLPCG_G_SPORT) begin : g_io
                assign dom_en = clk_io_en_o;
            end else if (g == `SLPCG_G_CONV) begin : g_cv
                assign dom_en = clk_conv_en_o;
            end else begin : g_tm
                assign dom_en = clk_io_en_o;
            end
            // Timers keep their own clock so enabled ones carry on
            if (g == `SLPCG_G_TIM0 || g == `SLPCG_G_TIM1) begin : g_t
                assign periph_clk_en_o[g] = dom_en;
            end else begin : g_n
                assign periph_clk_en_o[g] =
                    dom_en && !clk_gate_reg[g];
            end
            assign periph_acc_en_o[g] = !clk_gate_reg[g];
        end
    endgenerate

    assign comp_mux_en_o =
        !clk_gate_reg[`SLPCG_G_CONV] && clk_conv_en_o;

    // ------------------------------------------------------------
    // Converter off-on tracking
    // ------------------------------------------------------------
    // Converter enable is not touched by sleep; rising enable marks next
    // conversion as extended until the converter reports completion
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            conv_en_d_reg <= 1'b0;
            conv_ext_reg  <= 1'b1;
        end else begin
            conv_en_d_reg <= conv_enable_i;
            if (conv_enable_i && !conv_en_d_reg) begin
                conv_ext_reg <= 1'b1;
            end else if (converter_irq_i) begin
                conv_ext_reg <= 1'b0;
            end
        end
    end

    assign conv_extended_o = conv_ext_reg;
    assign core_halt_o     = (state_reg != SLPCG_RUN);
    assign irq_service_o   = (state_reg == SLPCG_HOLD) && cnt_done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sleep_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        state_reg == SLPCG_RUN && $past(state_reg) == SLPCG_RUN
        && !(sleep_instr_i && se_bit) |=> state_reg == SLPCG_RUN)
        else $error("sleep entered without enable and instruction");

    pdown_clocks_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        state_reg == SLPCG_SLEEP && mode_reg == `SLPCG_SM_PDOWN
        |-> !osc_en_o && !clk_io_en_o && !clk_conv_en_o)
        else $error("clock running in power-down");

    stby_osc_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        state_reg == SLPCG_SLEEP && mode_reg == `SLPCG_SM_STBY
        |-> osc_en_o && !clk_pll_en_o)
        else $error("standby oscillator state wrong");

    stby_wake_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        state_reg == SLPCG_SLEEP && mode_reg == `SLPCG_SM_STBY && wake_hit
        |-> ##[1:6] state_reg == SLPCG_RUN)
        else $error("standby wake too slow");

    pdown_filter_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        state_reg == SLPCG_SLEEP && mode_reg == `SLPCG_SM_PDOWN
        && ext_level_irq_i == 4'h0 && !stage_ctrl_irq_i && !watchdog_wake_i
        |=> state_reg == SLPCG_SLEEP)
        else $error("power-down woke on illegal source");

    hold_four_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(state_reg == SLPCG_HOLD)
        |-> (state_reg == SLPCG_HOLD) [*4] ##1 state_reg == SLPCG_RUN)
        else $error("interrupt hold not four cycles");

    gate_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_gate_reg[`SLPCG_G_SPI]
        |-> !periph_clk_en_o[`SLPCG_G_SPI] && !periph_acc_en_o[`SLPCG_G_SPI])
        else $error("gated peripheral clock running");

    comp_mux_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_gate_reg[`SLPCG_G_CONV] |-> !comp_mux_en_o)
        else $error("comparator uses mux while converter gated");
endmodule : slpcg_ctrl
`default_nettype wire

// ==== core/slpcg_wake_cnt.sv ====
// Down-counter that times the restart and hold period after wake-up
`timescale 1ns/10ps
`default_nettype none
module slpcg_wake_cnt #(
    parameter int CW = 16
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rstn_i,
    input  wire logic          load_i,
    input  wire logic [CW-1:0] value_i,
    output logic               done_o
);
    logic [CW-1:0] cnt_reg;

    // Load then count down to zero
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
        end else if (load_i) begin
            cnt_reg <= value_i;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Done looks at the count only, so a load that it starts cannot loop back
    assign done_o = (cnt_reg == '0);
endmodule : slpcg_wake_cnt
`default_nettype wire

// ==== include/slpcg_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SLPCG_MAP_SVH
`define SLPCG_MAP_SVH

// Register offsets
`define SLPCG_ADDR_W           4
`define SLPCG_OFF_MODE_CTRL    4'h0
`define SLPCG_OFF_CLK_GATE     4'h1
`define SLPCG_OFF_STATUS       4'h2
`define SLPCG_OFF_WAKE_CFG     4'h3

// Mode control fields
`define SLPCG_SE_BIT           0
`define SLPCG_SM_LSB           1
`define SLPCG_SM_MSB           3
`define SLPCG_MODE_CTRL_RST    8'h00
`define SLPCG_CLK_GATE_RST     8'h00

// Sleep mode encodings
`define SLPCG_SM_IDLE          3'h0
`define SLPCG_SM_NOISE         3'h1
`define SLPCG_SM_PDOWN         3'h2
`define SLPCG_SM_STBY          3'h6

// Gate register bit positions
`define SLPCG_G_CONV           0
`define SLPCG_G_SPORT          1
`define SLPCG_G_SPI            2
`define SLPCG_G_TIM0           3
`define SLPCG_G_TIM1           4
`define SLPCG_G_PSC0           5

// Timing: extra core hold and standby wake limit in cycles, and the counter width in bits
`define SLPCG_IRQ_HOLD_CYC     4
`define SLPCG_STBY_WAKE_CYC    6
`define SLPCG_CNT_W            16

`endif

// ==== include/slpcg_pkg.sv ====
// Types for the sleep and clock gating control block
package slpcg_pkg;
    typedef enum logic [2:0] {
        SLPCG_RUN   = 3'b000,
        SLPCG_SLEEP = 3'b001,
        SLPCG_START = 3'b011,
        SLPCG_HOLD  = 3'b010
    } slpcg_state_t;
endpackage : slpcg_pkg

// ==== tb/slpcg_ctrl_bench.sv ====
// Self-checking bench for the sleep and clock gating control block
`timescale 1ns/10ps
`default_nettype none
`include "slpcg_map.svh"
module slpcg_ctrl_bench;
    // ----------------------------------------
    // Signals and settings
    // ----------------------------------------
    localparam int FUSE = 5;    // Short restart delay keeps the run brief
    typedef struct {
        logic [2:0] mode;
        logic [3:0] dom;        // {io, conv, pll, osc} while asleep
        logic [8:0] ign;        // Sources that must not wake this mode
        logic [8:0] wake;       // Source that must wake it
        int         lo;
        int         hi;
    } slpcg_row_t;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [3:0]  addr_i    = 4'h0;
    logic [7:0]  wdata_i   = 8'h00;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        sleep_i   = 1'b0;
    logic        xtal_i    = 1'b1;
    logic        conv_on_i = 1'b1;
    logic [8:0]  wk        = 9'h000; // [3:0] ext, stage, store, conv, wdt, io
    logic [7:0]  rdata_o;
    logic        core_en_o, flash_en_o, io_en_o, conv_en_o, pll_en_o, osc_en_o;
    logic [7:0]  pclk_o;
    logic [7:0]  pacc_o;
    logic        mux_o, ext_o, halt_o, svc_o;
    logic [7:0]  d;
    logic        seen_svc;
    int          n;
    int          cycles     = 0;
    int          mismatches = 0;
    int          n_compared = 0;
    slpcg_row_t  rows [7];

    slpcg_ctrl #(.CW(16)) dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sleep_instr_i(sleep_i), .crystal_sel_i(xtal_i),
        .fuse_timeout_i(16'(FUSE)), .ext_level_irq_i(wk[3:0]),
        .stage_ctrl_irq_i(wk[4]), .store_ready_irq_i(wk[5]),
        .converter_irq_i(wk[6]), .watchdog_wake_i(wk[7]),
        .other_io_irq_i(wk[8]), .conv_enable_i(conv_on_i),
        .clk_core_en_o(core_en_o), .clk_flash_en_o(flash_en_o),
        .clk_io_en_o(io_en_o), .clk_conv_en_o(conv_en_o),
        .clk_pll_en_o(pll_en_o), .osc_en_o(osc_en_o),
        .periph_clk_en_o(pclk_o), .periph_acc_en_o(pacc_o),
        .comp_mux_en_o(mux_o), .conv_extended_o(ext_o),
        .core_halt_o(halt_o), .irq_service_o(svc_o));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    // 25 MHz clock
    always #20 ref_clk_i = ~ref_clk_i;

    // Cut the run short if a wait never ends
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // One sleep instruction; returns once its edge has landed
    task automatic sleep_pulse();
        @(posedge ref_clk_i);
        sleep_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_i <= 1'b0;
        #1;
    endtask : sleep_pulse

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows = '{
            '{3'h0, 4'hF, 9'h000, 9'h100, 5, 8},
            '{3'h0, 4'hF, 9'h000, 9'h001, 5, 8},
            '{3'h1, 4'h7, 9'h100, 9'h020, 5, 8},
            '{3'h1, 4'h7, 9'h100, 9'h040, 5, 8},
            '{3'h2, 4'h0, 9'h160, 9'h010, FUSE + 4, FUSE + 8},
            '{3'h2, 4'h0, 9'h160, 9'h080, FUSE + 4, FUSE + 8},
            '{3'h6, 4'h1, 9'h170, 9'h008, 5, 6}};
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        #1 check("conv_extended after reset", ext_o, 1'b1);
        check("clk after reset", pclk_o, 8'hFF);
        rd(`SLPCG_OFF_CLK_GATE);
        check("gate reset", d, `SLPCG_CLK_GATE_RST);
        rd(`SLPCG_OFF_MODE_CTRL);
        check("mode reset", d, `SLPCG_MODE_CTRL_RST);
        wr(`SLPCG_OFF_MODE_CTRL, 8'hFF);
        rd(`SLPCG_OFF_MODE_CTRL);
        check("mode upper bits", d, 8'h0F);
        wr(4'h3, 8'h5A);
        rd(4'h3);
        check("unmapped read", d, 8'h00);
        $display("test registers done");
        @(posedge ref_clk_i);
        conv_on_i <= 1'b0;

        // Each row: sleep, stray sources for rows that list any, then a real wake
        foreach (rows[i]) begin
            wr(`SLPCG_OFF_MODE_CTRL, {4'h0, rows[i].mode, 1'b1});
            sleep_pulse();
            check("domains", {io_en_o, conv_en_o, pll_en_o, osc_en_o},
                  rows[i].dom);
            check("core flash", {core_en_o, flash_en_o}, 2'b00);
            if (rows[i].ign != 9'h000) begin
                @(posedge ref_clk_i);
                wk <= rows[i].ign;
                repeat (8) @(posedge ref_clk_i);
                #1 check("stray wake", halt_o, 1'b1);
            end
            @(posedge ref_clk_i);
            wk <= rows[i].ign | rows[i].wake;
            n = 0;
            seen_svc = 1'b0;
            while (halt_o !== 1'b0 && n < 40) begin
                @(posedge ref_clk_i);
                #1 n++;
                if (svc_o === 1'b1)
                    seen_svc = 1'b1;
            end
            check("wake time", (n >= rows[i].lo && n <= rows[i].hi),
                  1'b1);
            check("service pulse", seen_svc, 1'b1);
            check("run clocks", {core_en_o, io_en_o, conv_en_o, osc_en_o},
                  4'hF);
            @(posedge ref_clk_i);
            wk <= 9'h000;
            $display("test sleep row %0d done", i);
        end

        // Sleep refused: enable clear, reserved codes, standby sans crystal
        foreach (rows[i]) begin
            if (i < 6) begin
                xtal_i <= (i != 5);
                wr(`SLPCG_OFF_MODE_CTRL, (i == 0) ? 8'h00 :
                   (i == 5) ? 8'h0D : (i == 4) ? 8'h0F :
                   {4'h0, 3'(i + 2), 1'b1});
                sleep_pulse();
                check("refused sleep", halt_o, 1'b0);
            end
        end
        xtal_i <= 1'b1;
        $display("test refused sleep done");

        // Peripheral gating and release
        wr(`SLPCG_OFF_CLK_GATE, 8'hA5);
        #1 check("access gated", pacc_o, 8'h5A);
        check("clocks gated", pclk_o, 8'h5A | 8'h18);
        check("mux blocked", mux_o, 1'b0);
        rd(`SLPCG_OFF_CLK_GATE);
        check("gate readback", d, 8'hA5);
        wr(`SLPCG_OFF_CLK_GATE, 8'h5A);
        #1 check("clocks gated 2", pclk_o, 8'hA5 | 8'h18);
        check("mux free", mux_o, 1'b1);
        wr(`SLPCG_OFF_CLK_GATE, 8'h00);
        #1 check("clocks released", pclk_o, 8'hFF);
        check("access released", pacc_o, 8'hFF);
        $display("test gating done");

        // Converter off and on forces an extended conversion
        check("conv_extended cleared", ext_o, 1'b0);
        @(posedge ref_clk_i);
        conv_on_i <= 1'b0;
        @(posedge ref_clk_i);
        conv_on_i <= 1'b1;
        @(posedge ref_clk_i);
        #1 check("conv_extended set", ext_o, 1'b1);
        $display("test converter done");

        // Reset in mid-sleep restarts in run
        wr(`SLPCG_OFF_MODE_CTRL, 8'h05);
        sleep_pulse();
        check("asleep", halt_o, 1'b1);
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        #1 check("reset wakes", halt_o, 1'b0);
        rd(`SLPCG_OFF_MODE_CTRL);
        check("mode cleared", d, 8'h00);
        rd(`SLPCG_OFF_STATUS);
        check("status after reset", d, 8'h20);
        $display("test reset in sleep done");
        report_and_stop();
    end
endmodule : slpcg_ctrl_bench
`default_nettype wire
